//--- verilog/aics_top.sv
// two-wire control slave with its control and status registers
// What this block does
// RULE1 - only ever answers as a target; never starts a transfer
// RULE2 - address is fixed upper bits plus two bits from the select pin
// RULE3 - address byte lsb one means read, zero means write
// RULE4 - idle watches for start: data falls while clock high
// RULE5 - shift eight address bits msb first; ack low on ninth clock
// RULE6 - wrong address releases the bus and goes idle
// RULE7 - stop, data rising while clock high, ends the transfer
// RULE8 - start anywhere aborts to address receive, stop anywhere aborts to idle, at once
// RULE9 - master gives at most one start, stop, or stop-start per clock high
// RULE10 - invalid subaddress gets no ack and goes idle
// RULE11 - read past top keeps returning top register until master nacks
// RULE12 - write past top drops the byte, nacks it, goes idle
// RULE13 - every written byte up to the top register is acked low on the ninth clock
// RULE14 - pointer advances by one after every byte until it reaches the top register; a read byte that the master nacks leaves it unchanged
// RULE15 - master reads via write of subaddress then repeated start read
// RULE16 - read returns a byte per register; master acks to continue
// RULE17 - regulator enable bit in 0x04 turns regulator on; off by default
// RULE18 - io level select in 0x20 defaults to 1.8 V, set selects 1.2 V
// RULE19 - amplifier held shut down until shutdown bit in 0x20 is cleared
// RULE20 - edge bit in 0x05 selects low-emi slew; normal by default
// RULE21 - soft reset bit in 0x2E forces defaults until written back to zero
// RULE22 - fault status readable at 0x11 at any time
// RULE23 - subaddress loads the pointer, kept for a repeated-start read
`timescale 1ns/1ps
`default_nettype none
module aics_top
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [1:0] addr_sel_i,
	input wire logic [7:0] fault_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output var aics_pkg::aics_ctrl_type amp_ctrl_o
);
	import aics_pkg::*;

	typedef struct packed
	{
		aics_state_type st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic over;
		logic drive_n;
		logic scl_q;
		logic sda_q;
		logic [7:0] reg_en;
		logic [7:0] amp_slew;
		logic [7:0] power;
		logic [7:0] soft_rst;
	} aics_top_state_type;

	aics_top_state_type cur;
	aics_top_state_type next_cur;
	logic [1:0] line_s;
	logic [1:0] addr_sel_s;
	logic [7:0] fault_s;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_full;
	logic addr_match;

	aics_sync #(.WIDTH(12), .RESET_VALUE(12'hC00)) u_sync_pins
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({scl_i, sda_i, addr_sel_i, fault_i}),
		.sync_o({line_s, addr_sel_s, fault_s})
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];
	assign scl_rise = scl_s && !cur.scl_q;
	assign scl_fall = !scl_s && cur.scl_q;
	assign start_det = scl_s && cur.scl_q && cur.sda_q && !sda_s;
	assign stop_det = scl_s && cur.scl_q && !cur.sda_q && sda_s;
	assign byte_full = (cur.cnt == BITS_PER_BYTE);
	assign addr_match = (cur.shift[7:1] == {ADDR_FIXED_HI, addr_sel_s}); // [RULE2]

	function automatic logic [7:0] read_byte(input aics_top_state_type s, input logic [7:0] flt);
		logic [7:0] r;
		r = 8'h00;
		unique case (s.ptr)
			SUB_REG_EN: r = s.reg_en;
			SUB_AMP_SLEW: r = s.amp_slew;
			SUB_FAULT: r = flt; // [RULE22]
			SUB_POWER: r = s.power;
			SUB_SOFT_RST: r = s.soft_rst;
			default: r = 8'h00;
		endcase
		return r;
	endfunction : read_byte

	always_comb
	begin
		next_cur = cur;
		next_cur.scl_q = scl_s;
		next_cur.sda_q = sda_s;
		if (start_det)
		begin
			next_cur.st = ST_ADDR; // [RULE4] [RULE8]
			next_cur.cnt = 4'h0;
			next_cur.drive_n = 1'b1;
		end
		else if (stop_det)
		begin
			next_cur.st = ST_IDLE; // [RULE7] [RULE8]
			next_cur.drive_n = 1'b1;
		end
		else
		begin
			unique case (cur.st)
				ST_IDLE:
				begin
					next_cur.drive_n = 1'b1; // [RULE1]
				end
				ST_ADDR, ST_SUB, ST_WDATA:
				begin
					if (scl_rise && !byte_full)
					begin
						next_cur.shift = {cur.shift[6:0], sda_s}; // [RULE5]
						next_cur.cnt = cur.cnt + 4'h1;
					end
					else if (scl_fall && byte_full)
					begin
						next_cur.cnt = 4'h0;
						if (cur.st == ST_ADDR)
						begin
							if (addr_match)
							begin
								next_cur.st = ST_ADDR_ACK;
								next_cur.drive_n = 1'b0; // [RULE5]
							end
							else
								next_cur.st = ST_IDLE; // [RULE6]
						end
						else if (cur.st == ST_SUB)
						begin
							if (cur.shift > SUB_TOP)
								next_cur.st = ST_IDLE; // [RULE10]
							else
							begin
								next_cur.ptr = cur.shift; // [RULE23]
								next_cur.over = 1'b0;
								next_cur.st = ST_SUB_ACK;
								next_cur.drive_n = 1'b0;
							end
						end
						else if (cur.over)
							next_cur.st = ST_IDLE; // [RULE12]
						else
						begin
							next_cur.st = ST_WDATA_ACK;
							next_cur.drive_n = 1'b0; // [RULE13]
							unique case (cur.ptr)
								SUB_REG_EN: next_cur.reg_en = cur.shift; // [RULE17]
								SUB_AMP_SLEW: next_cur.amp_slew = cur.shift; // [RULE20]
								SUB_POWER: next_cur.power = cur.shift; // [RULE18] [RULE19]
								SUB_SOFT_RST: next_cur.soft_rst = cur.shift; // [RULE21]
								default: next_cur.reg_en = cur.reg_en;
							endcase
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						if (cur.shift[0])
						begin
							next_cur.st = ST_RDATA; // [RULE3]
							next_cur.shift = read_byte(cur, fault_s);
							next_cur.drive_n = next_cur.shift[7]; // [RULE16]
						end
						else
						begin
							next_cur.st = ST_SUB; // [RULE3]
							next_cur.drive_n = 1'b1;
						end
					end
				end
				ST_SUB_ACK:
				begin
					if (scl_fall)
					begin
						next_cur.st = ST_WDATA;
						next_cur.drive_n = 1'b1;
					end
				end
				ST_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						next_cur.st = ST_WDATA;
						next_cur.drive_n = 1'b1;
						if (cur.ptr == SUB_TOP)
							next_cur.over = 1'b1; // [RULE12]
						else
							next_cur.ptr = cur.ptr + 8'h01; // [RULE14]
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
						next_cur.cnt = cur.cnt + 4'h1;
					else if (scl_fall)
					begin
						if (byte_full)
						begin
							next_cur.st = ST_RDATA_ACK;
							next_cur.drive_n = 1'b1;
						end
						else
						begin
							next_cur.shift = {cur.shift[6:0], 1'b0};
							next_cur.drive_n = cur.shift[6]; // [RULE16]
						end
					end
				end
				ST_RDATA_ACK:
				begin
					if (scl_rise && sda_s)
						next_cur.st = ST_IDLE; // [RULE11] [RULE16]
					else if (scl_fall)
					begin
						next_cur.cnt = 4'h0;
						next_cur.st = ST_RDATA;
						if (cur.ptr != SUB_TOP)
							next_cur.ptr = cur.ptr + 8'h01; // [RULE14] [RULE11]
						next_cur.shift = read_byte(next_cur, fault_s);
						next_cur.drive_n = next_cur.shift[7];
					end
				end
				default:
				begin
					next_cur.st = ST_IDLE;
					next_cur.drive_n = 1'b1;
				end
			endcase
		end
		if (next_cur.soft_rst[SOFT_RST_BIT])
		begin
			next_cur.reg_en = REG_EN_RST; // [RULE21]
			next_cur.amp_slew = AMP_SLEW_RST;
			next_cur.power = POWER_RST;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur.st <= ST_IDLE;
			cur.cnt <= 4'h0;
			cur.shift <= 8'h00;
			cur.ptr <= 8'h00;
			cur.over <= 1'b0;
			cur.drive_n <= 1'b1;
			cur.scl_q <= 1'b1;
			cur.sda_q <= 1'b1;
			cur.reg_en <= REG_EN_RST;
			cur.amp_slew <= AMP_SLEW_RST;
			cur.power <= POWER_RST;
			cur.soft_rst <= SOFT_RST_RST;
		end
		else
			cur <= next_cur;
	end

	assign sda_o = 1'b0;
	assign sda_oe_n_o = cur.drive_n;
	assign amp_ctrl_o.regulator_en = cur.reg_en[REG_EN_BIT]; // [RULE17]
	assign amp_ctrl_o.io_supply_level_sel = cur.power[IO_SEL_BIT]; // [RULE18]
	assign amp_ctrl_o.amp_shutdown = cur.power[SHUTDOWN_BIT]; // [RULE19]
	assign amp_ctrl_o.low_emi_slew = cur.amp_slew[SLEW_EDGE_BIT]; // [RULE20]
	assign amp_ctrl_o.soft_reset = cur.soft_rst[SOFT_RST_BIT]; // [RULE21]

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_byte_end;
		byte_full && scl_fall;
	endsequence
	property p_idle_quiet;
		cur.st == ST_IDLE |-> cur.drive_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle"); // [RULE1]
	property p_start_addr;
		start_det |=> cur.st == ST_ADDR && cur.cnt == 4'h0 && cur.drive_n;
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start not taken"); // [RULE4]
	property p_stop_idle;
		stop_det |=> cur.st == ST_IDLE && cur.drive_n;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not taken"); // [RULE8]
	property p_addr_ack;
		cur.st == ST_ADDR ##0 s_byte_end ##0 addr_match |=> cur.st == ST_ADDR_ACK && !cur.drive_n;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // [RULE5]
	property p_addr_miss;
		cur.st == ST_ADDR ##0 s_byte_end ##0 !addr_match |=> cur.st == ST_IDLE && cur.drive_n;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked"); // [RULE6]
	property p_bad_sub;
		cur.st == ST_SUB ##0 s_byte_end ##0 cur.shift > SUB_TOP |=> cur.st == ST_IDLE && cur.drive_n;
	endproperty
	a_bad_sub: assert property (p_bad_sub) else $error("invalid subaddress acked"); // [RULE10]
	property p_write_over;
		cur.st == ST_WDATA ##0 s_byte_end ##0 cur.over
			|=> cur.st == ST_IDLE && cur.drive_n && $stable(cur.power) && $stable(cur.reg_en);
	endproperty
	a_write_over: assert property (p_write_over) else $error("overflow byte accepted"); // [RULE12]
	property p_write_ack;
		$rose(cur.st == ST_WDATA_ACK) |-> !cur.drive_n ##1 (!cur.drive_n || cur.st != ST_WDATA_ACK);
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("write ack missing"); // [RULE13]
	property p_ptr_step;
		cur.st == ST_WDATA_ACK && scl_fall && cur.ptr != SUB_TOP |=> cur.ptr == $past(cur.ptr) + 8'h01;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance"); // [RULE14]
	property p_read_sat;
		cur.st == ST_RDATA_ACK && scl_fall && cur.ptr == SUB_TOP |=> cur.ptr == SUB_TOP && cur.st == ST_RDATA;
	endproperty
	a_read_sat: assert property (p_read_sat) else $error("read pointer passed top"); // [RULE11]
	property p_soft_reset;
		cur.soft_rst[SOFT_RST_BIT]
			|-> cur.power == POWER_RST && cur.amp_slew == AMP_SLEW_RST && cur.reg_en == REG_EN_RST;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("settings moved during soft reset"); // [RULE21]
endmodule : aics_top
`default_nettype wire

//--- verilog/aics_pkg.sv
// shared constants and types for the amplifier two-wire control slave
package aics_pkg;
	localparam logic [4:0] ADDR_FIXED_HI = 5'h09;
	localparam logic [7:0] SUB_REG_EN = 8'h04;
	localparam logic [7:0] SUB_AMP_SLEW = 8'h05;
	localparam logic [7:0] SUB_FAULT = 8'h11;
	localparam logic [7:0] SUB_POWER = 8'h20;
	localparam logic [7:0] SUB_SOFT_RST = 8'h2E;
	localparam logic [7:0] SUB_TOP = 8'h2E;
	localparam logic [7:0] REG_EN_RST = 8'h00;
	localparam logic [7:0] AMP_SLEW_RST = 8'h22;
	localparam logic [7:0] POWER_RST = 8'h05;
	localparam logic [7:0] SOFT_RST_RST = 8'h00;
	localparam int REG_EN_BIT = 0;
	localparam int SLEW_EDGE_BIT = 2;
	localparam int SHUTDOWN_BIT = 0;
	localparam int IO_SEL_BIT = 1;
	localparam int SOFT_RST_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_SUB = 4'b0011,
		ST_SUB_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} aics_state_type;

	typedef struct packed
	{
		logic regulator_en;
		logic io_supply_level_sel;
		logic amp_shutdown;
		logic low_emi_slew;
		logic soft_reset;
	} aics_ctrl_type;
endpackage : aics_pkg

//--- verilog/aics_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module aics_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import aics_pkg::*;

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} aics_sync_state_type;

	aics_sync_state_type cur;
	aics_sync_state_type next_cur;

	if (WIDTH < 1)
	begin : g_chk
		$error("aics_sync width must be at least one");
	end

	always_comb
	begin
		next_cur.meta = async_i;
		next_cur.stable = cur.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cur <= {RESET_VALUE, RESET_VALUE};
		else
			cur <= next_cur;
	end

	assign sync_o = cur.stable;
endmodule : aics_sync
`default_nettype wire

//--- bench/aics_master.sv
// behavioural two-wire bus master driving the control slave
`timescale 1ns/1ps
`default_nettype none
module aics_master
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_n_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic half();
		repeat (16) @(negedge clk_i);
	endtask : half
	// start or repeated start, data falls while clock high
	task automatic start();
		sda_oe_n_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_oe_n_o = 1'b0;
		half();
		scl_o = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask : start
	// single stop per clock high, data rises while clock high
	task automatic stop();
		sda_oe_n_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_oe_n_o = 1'b1;
		half();
	endtask : stop
	// data set while clock low, sampled at end of clock high
	task automatic bit_io(input logic b, output logic s);
		sda_oe_n_o = b;
		repeat (12) @(negedge clk_i);
		scl_o = 1'b1;
		half();
		s = sda_i;
		scl_o = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask : bit_io
	// msb first, ninth clock released for the slave
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, ack);
	endtask : wbyte
	// master acks to continue, nack ends the read
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, s);
	endtask : rbyte
endmodule : aics_master
`default_nettype wire

//--- bench/test_aics_top.sv
// self-checking bench for the two-wire control slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_aics_top;
	import aics_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] addr_sel_i = 2'h1;
	logic [7:0] fault_i = 8'h00;
	wire scl;
	wire m_oe_n;
	wire sda;
	wire sda_o;
	wire sda_oe_n_o;
	aics_ctrl_type amp_ctrl_o;
	int err_count = 0;
	int check_count = 0;
	// pull-up wire: low if either party enables its driver
	assign sda = m_oe_n & (sda_oe_n_o | sda_o);
	initial
		forever #2.5 clk_i = ~clk_i;
	aics_top uut
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.scl_i(scl),
		.sda_i(sda),
		.addr_sel_i(addr_sel_i),
		.fault_i(fault_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.amp_ctrl_o(amp_ctrl_o)
	);
	aics_master m
	(
		.clk_i(clk_i),
		.sda_i(sda),
		.scl_o(scl),
		.sda_oe_n_o(m_oe_n)
	);
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic hdr(input logic rw, output logic ack);
		m.wbyte({ADDR_FIXED_HI, addr_sel_i, rw}, ack);
	endtask : hdr
	task automatic wr(input logic [7:0] sub, input logic [7:0] d[$], input int n_ok);
		logic ack;
		m.start();
		hdr(1'b0, ack);
		`CHK(ack, 1'b0)
		m.wbyte(sub, ack);
		`CHK(ack, 1'b0)
		foreach (d[i])
		begin
			m.wbyte(d[i], ack);
			`CHK(ack, i >= n_ok)
		end
		m.stop();
	endtask : wr
	task automatic rd(input logic [7:0] sub, input logic [7:0] exp[$]);
		logic ack;
		logic [7:0] d;
		m.start();
		hdr(1'b0, ack);
		m.wbyte(sub, ack);
		m.start();
		hdr(1'b1, ack);
		`CHK(ack, 1'b0)
		foreach (exp[i])
		begin
			m.rbyte(i == exp.size() - 1, d);
			`CHK(d, exp[i])
		end
		m.stop();
	endtask : rd
	task automatic t_defaults();
		`CHK(amp_ctrl_o, 5'h04)
		`CHK(sda_oe_n_o, 1'b1)
		`CHK(sda_o, 1'b0)
		rd(SUB_REG_EN, {8'h00, 8'h22});
		rd(SUB_POWER, {8'h05});
	endtask : t_defaults
	task automatic t_address();
		logic ack;
		for (int p = 0; p < 4; p++)
			for (int a = 0; a < 4; a++)
			begin
				addr_sel_i = 2'(p);
				repeat (4) @(negedge clk_i);
				m.start();
				m.wbyte({ADDR_FIXED_HI, 2'(a), 1'b0}, ack);
				`CHK(ack, a != p)
				m.stop();
			end
		addr_sel_i = 2'h1;
	endtask : t_address
	task automatic t_write();
		wr(SUB_REG_EN, {8'h01, 8'h26}, 2);
		`CHK(amp_ctrl_o, 5'h16)
		wr(SUB_POWER, {8'h02}, 1);
		`CHK(amp_ctrl_o, 5'h1A)
		rd(SUB_AMP_SLEW, {8'h26, 8'h00});
	endtask : t_write
	task automatic t_fault();
		fault_i = 8'hA5;
		rd(SUB_FAULT, {8'hA5});
		fault_i = 8'h3C;
		rd(SUB_FAULT, {8'h3C, 8'h00});
	endtask : t_fault
	task automatic t_invalid();
		logic ack;
		m.start();
		hdr(1'b0, ack);
		m.wbyte(8'h2F, ack);
		`CHK(ack, 1'b1)
		m.wbyte(8'h01, ack);
		`CHK(ack, 1'b1)
		m.stop();
	endtask : t_invalid
	task automatic t_top();
		wr(SUB_SOFT_RST, {8'h01, 8'h55}, 1);
		`CHK(amp_ctrl_o, 5'h05)
		wr(SUB_REG_EN, {8'h01}, 1);
		`CHK(amp_ctrl_o, 5'h05)
		rd(SUB_SOFT_RST, {8'h01, 8'h01, 8'h01});
		wr(SUB_SOFT_RST, {8'h00}, 1);
		`CHK(amp_ctrl_o, 5'h04)
	endtask : t_top
	task automatic t_abort();
		logic ack;
		m.start();
		hdr(1'b0, ack);
		for (int i = 0; i < 3; i++)
			m.bit_io(1'b0, ack);
		m.start();
		hdr(1'b0, ack);
		`CHK(ack, 1'b0)
		m.bit_io(1'b1, ack);
		m.stop();
		`CHK(sda_oe_n_o, 1'b1)
		wr(SUB_REG_EN, {8'h01}, 1);
		`CHK(amp_ctrl_o, 5'h14)
	endtask : t_abort
	initial
	begin
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		t_defaults();
		t_address();
		t_write();
		t_fault();
		t_invalid();
		t_top();
		t_abort();
		finish_test();
	end
	initial
	begin
		repeat (90000) @(posedge clk_i);
		err_count++;
		finish_test();
	end
endmodule : test_aics_top
`default_nettype wire
